// ==== pms_consts.svh ====
// Purpose: Offsets, field positions, reset values and timing counts of the power-mode sequencer
// Assumes: 32-bit AHB-Lite register bus, clock at 125 MHz
// Notes:   Definitions only
`ifndef PMS_CONSTS_SVH
`define PMS_CONSTS_SVH

// ==========================================================================
// Register offsets (byte addresses)
`define PMS_ADDR_TASKS      12'h000
`define PMS_ADDR_STATUS     12'h004
`define PMS_ADDR_RAM_POWER  12'h008
`define PMS_ADDR_WAKE_CAUSE 12'h00c
`define PMS_ADDR_W          12

// ==========================================================================
// Task register bits (write one to trigger)
`define PMS_TASK_SYS_OFF    0
`define PMS_TASK_FIXED_LAT  1
`define PMS_TASK_LOW_POWER  2

// Status register fields
`define PMS_ST_STATE_LSB    0
`define PMS_ST_CONST_LAT    8
`define PMS_ST_REG_EN       9
`define PMS_ST_CORE_PWR     10
`define PMS_ST_SYS_RESET    11

// RAM power register: power bits in [15:0], retention bits in [31:16]
`define PMS_RAM_RET_LSB     16
`define PMS_RAM_POWER_RST   32'h0000ffff

// Wake-cause bits, sticky, write one to clear
`define PMS_WC_DETECT       0
`define PMS_WC_RESET        1
`define PMS_WC_DEBUG        2
`define PMS_WC_POWER_ON     3
`define PMS_WC_W            4

// ==========================================================================
// Timing
`define PMS_CLK_KHZ         125000
`define PMS_T_POR_US        1200
`define PMS_T_OFF2ON_US     73
`define PMS_POR_CYCLES      ((`PMS_T_POR_US * `PMS_CLK_KHZ) / 1000)
`define PMS_WAKE_CYCLES     ((`PMS_T_OFF2ON_US * `PMS_CLK_KHZ) / 1000)
`define PMS_OFF_ENTRY_CYCLES 16

`endif

// ==== pms_host_model.sv ====
// Purpose: Outside host: enable pin, wake sources and debug lines
// Assumes: Levels change just after a rising hclk edge
// Notes:   Wake pulses last one cycle, long enough to be sampled
`timescale 1ns/1ps
`default_nettype none
module pms_host_model (
    input  wire logic hclk,
    output var logic  enable_pin,
    output var logic  gpio_detect,
    output var logic  reset_req,
    output var logic  debug_start,
    output var logic  debug_active
);
    initial begin
        enable_pin   = 1'b1;
        gpio_detect  = 1'b0;
        reset_req    = 1'b0;
        debug_start  = 1'b0;
        debug_active = 1'b0;
    end

    // ======================================================================
    // Host actions
    task automatic set_enable(input logic v);
        @(posedge hclk);
        enable_pin <= v;
    endtask

    task automatic set_debug(input logic v);
        @(posedge hclk);
        debug_active <= v;
    endtask

    // Source 0 detect, 1 reset, 2 debug start
    task automatic pulse(input int k);
        @(posedge hclk);
        case (k)
            0: gpio_detect <= 1'b1;
            1: reset_req <= 1'b1;
            default: debug_start <= 1'b1;
        endcase
        @(posedge hclk);
        gpio_detect <= 1'b0;
        reset_req   <= 1'b0;
        debug_start <= 1'b0;
    endtask
endmodule // pms_host_model
`default_nettype wire

// ==== pms_pkg.sv ====
// Purpose: Types of the power-mode sequencer
// Assumes: Constants live in pms_consts.svh
// Notes:   One-hot state codes
package pms_pkg;

    // ======================================================================
    // Power-mode states
    typedef enum logic [6:0] {
        PMS_S_DISABLED = 7'h01,
        PMS_S_POR      = 7'h02,
        PMS_S_ON       = 7'h04,
        PMS_S_OFF_ENT  = 7'h08,
        PMS_S_OFF      = 7'h10,
        PMS_S_EMU_OFF  = 7'h20,
        PMS_S_WAKE_RST = 7'h40
    } pms_state_t;

endpackage

// ==== pms_steer.sv ====
// Purpose: Resource steering per function block while the system runs
// Assumes: Activity inputs are synchronous to hclk
// Notes:   Outputs are registered
`timescale 1ns/1ps
`default_nettype none
module pms_steer
    import pms_pkg::*;
#(
    parameter int NBLK = 4
) (
    input  wire logic            hclk,
    input  wire logic            hresetn,
    input  wire logic            run,
    input  wire logic            hold_base,
    input  wire logic [NBLK-1:0] blk_active,
    output logic      [NBLK-1:0] blk_idle,
    output logic                 reg_req,
    output logic                 clk_req
);
    // ======================================================================
    // Next values
    logic [NBLK-1:0] idle_nxt;
    logic            reg_nxt;
    logic            clk_nxt;

    always_comb begin
        // Inactive blocks idle with state kept; they leave idle on activity [RULE15]
        idle_nxt = run ? ~blk_active : {NBLK{1'b1}};
        // Regulators and clocks follow the set of active blocks [RULE16]
        // Base set held in constant latency and emulated off [RULE17] [RULE12]
        reg_nxt  = run & (hold_base | (|blk_active));
        clk_nxt  = run & (hold_base | (|blk_active));
    end

    // ======================================================================
    // Registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            blk_idle <= {NBLK{1'b1}};
            reg_req  <= 1'b0;
            clk_req  <= 1'b0;
        end else begin
            blk_idle <= idle_nxt;
            reg_req  <= reg_nxt;
            clk_req  <= clk_nxt;
        end
    end

    initial begin
        if (NBLK < 1 || NBLK > 32) begin
            $error("pms_steer: NBLK must be 1..32");
        end
    end
endmodule // pms_steer
`default_nettype wire

// ==== pms_top.sv ====
// Purpose: Power-mode sequencer: disabled, running and off modes with wake reset
// Assumes: AHB-Lite slave with zero wait states; all inputs synchronous to hclk
// Notes:   hresetn is the power-on reset of the whole block
//
// Function
// RULE1: Enable pin low switches regulator off
// RULE2: Disabled mode overrides all internal requests
// RULE3: No operation while enable pin is low
// RULE4: Enable rising runs the power-on sequence
// RULE5: Software requests off mode by register write
// RULE6: Off mode powers core down, aborts tasks
// RULE7: Wake on detect, reset or debug start
// RULE8: Waking from off performs full system reset
// RULE9: RAM settings survive off and wake reset
// RULE10: Software stops DMA before requesting off
// RULE11: Software stops modem before requesting off
// RULE12: Under debug, off is only emulated
// RULE13: Software loops forever after off request
// RULE14: Power-on reset enters running, low-power
// RULE15: Inactive blocks idle, resume on activity
// RULE16: Regulators and clocks follow active blocks
// RULE17: Fixed latency task holds base resources
// RULE18: Low power task restores automatic management
// RULE19: RAM blocks powered per setting while running
// RULE20: Wake during off entry resets at once
//
// Local design decisions: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pms_consts.svh"
module pms_top
    import pms_pkg::*;
#(
    parameter int NBLK        = 4,
    parameter int NRAM        = 16,
    parameter int POR_CYCLES  = `PMS_POR_CYCLES,
    parameter int WAKE_CYCLES = `PMS_WAKE_CYCLES
) (
    input  wire logic            hclk,
    input  wire logic            hresetn,
    input  wire logic            hsel,
    input  wire logic [31:0]     haddr,
    input  wire logic [1:0]      htrans,
    input  wire logic            hwrite,
    input  wire logic [2:0]      hsize,
    input  wire logic [31:0]     hwdata,
    input  wire logic            hready,
    output logic      [31:0]     hrdata,
    output logic                 hreadyout,
    output logic                 hresp,
    input  wire logic            enable_pin,
    input  wire logic            gpio_detect,
    input  wire logic            reset_req,
    input  wire logic            debug_active,
    input  wire logic            debug_start,
    input  wire logic [NBLK-1:0] blk_active,
    output logic      [NBLK-1:0] blk_idle,
    output logic                 regulator_en,
    output logic                 core_power_en,
    output logic                 sys_reset_n,
    output logic                 cpu_run,
    output logic                 task_abort,
    output logic                 res_reg_req,
    output logic                 res_clk_req,
    output logic                 base_res_en,
    output logic      [NRAM-1:0] ram_power_on,
    output logic      [NRAM-1:0] ram_retain
);
    localparam int CNT_W = 24;

    // ======================================================================
    // Declarations
    pms_state_t                  state_r, state_nxt;
    logic [CNT_W-1:0]            cnt_r, cnt_nxt;
    logic                        const_lat_r, const_lat_nxt;
    logic [31:0]                 ram_pwr_r, ram_pwr_nxt;
    logic [`PMS_WC_W-1:0]        wake_r, wake_nxt;
    logic                        wr_pend_r, wr_pend_nxt;
    logic [`PMS_ADDR_W-1:0]      wr_addr_r, wr_addr_nxt;
    logic [31:0]                 hrdata_nxt;
    logic                        addr_ph;
    logic                        wr_tasks, wr_ram, wr_wake;
    logic                        task_off, task_fix, task_low;
    logic                        wake_src;
    logic                        enable_q_r;
    logic                        run;

    // ======================================================================
    // Bus slave: zero wait, always OKAY; writes land in the data phase
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign addr_ph   = hsel & hready & htrans[1];

    assign wr_tasks = wr_pend_r & (wr_addr_r == `PMS_ADDR_TASKS);
    assign wr_ram   = wr_pend_r & (wr_addr_r == `PMS_ADDR_RAM_POWER);
    assign wr_wake  = wr_pend_r & (wr_addr_r == `PMS_ADDR_WAKE_CAUSE);
    // Tasks have effect only while running; disabled ignores them [RULE3]
    assign task_off = wr_tasks & hwdata[`PMS_TASK_SYS_OFF];        // [RULE5]
    assign task_fix = wr_tasks & hwdata[`PMS_TASK_FIXED_LAT];
    assign task_low = wr_tasks & hwdata[`PMS_TASK_LOW_POWER];

    always_comb begin
        wr_pend_nxt = addr_ph & hwrite;
        wr_addr_nxt = addr_ph ? haddr[`PMS_ADDR_W-1:0] : wr_addr_r;
        hrdata_nxt  = 32'h0000_0000;
        if (addr_ph && !hwrite) begin
            case (haddr[`PMS_ADDR_W-1:0])
                `PMS_ADDR_STATUS: begin
                    hrdata_nxt[`PMS_ST_STATE_LSB +: 7] = state_r;
                    hrdata_nxt[`PMS_ST_CONST_LAT]     = const_lat_r;
                    hrdata_nxt[`PMS_ST_REG_EN]        = regulator_en;
                    hrdata_nxt[`PMS_ST_CORE_PWR]      = core_power_en;
                    hrdata_nxt[`PMS_ST_SYS_RESET]     = ~sys_reset_n;
                end
                `PMS_ADDR_RAM_POWER:  hrdata_nxt = ram_pwr_r;
                `PMS_ADDR_WAKE_CAUSE: hrdata_nxt[`PMS_WC_W-1:0] = wake_r;
                default:              hrdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= '0;
            hrdata    <= 32'h0000_0000;
        end else begin
            wr_pend_r <= wr_pend_nxt;
            wr_addr_r <= wr_addr_nxt;
            hrdata    <= hrdata_nxt;
        end
    end

    // ======================================================================
    // Mode sequencer
    // Wakeup sources that stay alive in off mode [RULE7]
    assign wake_src = gpio_detect | reset_req | debug_start;

    always_comb begin
        state_nxt     = state_r;
        cnt_nxt       = cnt_r;
        const_lat_nxt = const_lat_r;
        // Disabled overrides every internal request [RULE2]
        if (!enable_pin) begin
            state_nxt     = PMS_S_DISABLED;                         // [RULE1]
            cnt_nxt       = '0;
            const_lat_nxt = 1'b0;
        end else begin
            case (state_r)
                PMS_S_DISABLED: begin
                    // Enable returning starts the power-on sequence [RULE4]
                    state_nxt = PMS_S_POR;
                    cnt_nxt   = CNT_W'(POR_CYCLES - 1);
                end
                PMS_S_POR: begin
                    if (cnt_r == '0) begin
                        state_nxt     = PMS_S_ON;                   // [RULE14]
                        const_lat_nxt = 1'b0;
                    end else begin
                        cnt_nxt = cnt_r - 1'b1;
                    end
                end
                PMS_S_ON: begin
                    if (reset_req) begin
                        state_nxt = PMS_S_WAKE_RST;
                        cnt_nxt   = CNT_W'(WAKE_CYCLES - 1);
                    end else if (task_off) begin
                        state_nxt = debug_active ? PMS_S_EMU_OFF : PMS_S_OFF_ENT; // [RULE12]
                        cnt_nxt   = CNT_W'(`PMS_OFF_ENTRY_CYCLES - 1);
                    end else if (task_fix) begin
                        const_lat_nxt = 1'b1;                       // [RULE17]
                    end else if (task_low) begin
                        const_lat_nxt = 1'b0;                       // [RULE18]
                    end
                end
                PMS_S_OFF_ENT: begin
                    if (wake_src) begin
                        state_nxt = PMS_S_WAKE_RST;                 // [RULE20]
                        cnt_nxt   = CNT_W'(WAKE_CYCLES - 1);
                    end else if (cnt_r == '0) begin
                        state_nxt = PMS_S_OFF;                      // [RULE6]
                    end else begin
                        cnt_nxt = cnt_r - 1'b1;
                    end
                end
                PMS_S_OFF, PMS_S_EMU_OFF: begin
                    if (wake_src) begin
                        state_nxt = PMS_S_WAKE_RST;                 // [RULE8]
                        cnt_nxt   = CNT_W'(WAKE_CYCLES - 1);
                    end
                end
                PMS_S_WAKE_RST: begin
                    if (cnt_r == '0) begin
                        state_nxt     = PMS_S_ON;
                        const_lat_nxt = 1'b0;
                    end else begin
                        cnt_nxt = cnt_r - 1'b1;
                    end
                end
                default: begin
                    state_nxt = PMS_S_DISABLED;
                    cnt_nxt   = '0;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r     <= PMS_S_DISABLED;
            cnt_r       <= '0;
            const_lat_r <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            cnt_r       <= cnt_nxt;
            const_lat_r <= const_lat_nxt;
        end
    end

    // ======================================================================
    // RAM power settings and wake cause
    // Kept through off and wake reset; only disabled mode and a power-on sequence reload them
    always_comb begin
        ram_pwr_nxt = ram_pwr_r;
        wake_nxt    = wake_r;
        if (state_r == PMS_S_POR || state_r == PMS_S_DISABLED) begin
            ram_pwr_nxt = `PMS_RAM_POWER_RST;
        end else if (wr_ram && state_r == PMS_S_ON) begin
            ram_pwr_nxt = hwdata;                                   // [RULE9]
        end
        // Clear first, so a cause arriving in the same cycle wins
        if (wr_wake) begin
            wake_nxt = wake_r & ~hwdata[`PMS_WC_W-1:0];
        end
        if (state_r == PMS_S_OFF_ENT || state_r == PMS_S_OFF || state_r == PMS_S_EMU_OFF) begin
            if (gpio_detect) wake_nxt[`PMS_WC_DETECT] = 1'b1;
            if (reset_req)   wake_nxt[`PMS_WC_RESET]  = 1'b1;
            if (debug_start) wake_nxt[`PMS_WC_DEBUG]  = 1'b1;
        end else if (state_r == PMS_S_ON && reset_req) begin
            wake_nxt[`PMS_WC_RESET] = 1'b1;
        end
        if (enable_pin && !enable_q_r) begin
            wake_nxt = '0;
            wake_nxt[`PMS_WC_POWER_ON] = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ram_pwr_r  <= `PMS_RAM_POWER_RST;
            wake_r     <= '0;
            enable_q_r <= 1'b0;
        end else begin
            ram_pwr_r  <= ram_pwr_nxt;
            wake_r     <= wake_nxt;
            enable_q_r <= enable_pin;
        end
    end

    // ======================================================================
    // Outputs
    // Emulated off keeps the debug resources alive, so the CPU keeps running
    assign run = (state_r == PMS_S_ON) | (state_r == PMS_S_EMU_OFF);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            regulator_en  <= 1'b0;
            core_power_en <= 1'b0;
            sys_reset_n   <= 1'b0;
            cpu_run       <= 1'b0;
            task_abort    <= 1'b0;
            base_res_en   <= 1'b0;
            ram_power_on  <= '0;
            ram_retain    <= '0;
        end else begin
            regulator_en  <= enable_pin;                            // [RULE1] [RULE2]
            core_power_en <= enable_pin & (state_nxt != PMS_S_OFF)
                             & (state_nxt != PMS_S_DISABLED);       // [RULE6]
            sys_reset_n   <= (state_nxt == PMS_S_ON) | (state_nxt == PMS_S_OFF_ENT)
                             | (state_nxt == PMS_S_OFF) | (state_nxt == PMS_S_EMU_OFF); // [RULE3]
            cpu_run       <= (state_nxt == PMS_S_ON) | (state_nxt == PMS_S_EMU_OFF);   // [RULE12]
            task_abort    <= (state_nxt == PMS_S_OFF_ENT) | (state_nxt == PMS_S_OFF);  // [RULE6]
            base_res_en   <= ((state_nxt == PMS_S_ON) & const_lat_nxt)
                             | (state_nxt == PMS_S_EMU_OFF);        // [RULE17]
            if (state_nxt == PMS_S_OFF) begin
                // Only retained blocks stay supplied through off [RULE9]
                ram_power_on <= ram_pwr_nxt[`PMS_RAM_RET_LSB +: NRAM];
            end else if (state_nxt == PMS_S_DISABLED) begin
                ram_power_on <= '0;
            end else begin
                ram_power_on <= ram_pwr_nxt[NRAM-1:0];              // [RULE19]
            end
            ram_retain    <= ram_pwr_nxt[`PMS_RAM_RET_LSB +: NRAM]; // [RULE19]
        end
    end

    pms_steer #(
        .NBLK (NBLK)
    ) u_steer (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .run        (run),
        .hold_base  (const_lat_r | (state_r == PMS_S_EMU_OFF)),
        .blk_active (blk_active),
        .blk_idle   (blk_idle),
        .reg_req    (res_reg_req),
        .clk_req    (res_clk_req)
    );

    initial begin
        if (NRAM < 1 || NRAM > 16) begin
            $error("pms_top: NRAM must be 1..16");
        end
        if (POR_CYCLES < 1 || POR_CYCLES >= (1 << CNT_W)) begin
            $error("pms_top: POR_CYCLES out of range");
        end
        if (WAKE_CYCLES < 1 || WAKE_CYCLES >= (1 << CNT_W)) begin
            $error("pms_top: WAKE_CYCLES out of range");
        end
    end
endmodule // pms_top
`default_nettype wire

// ==== pms_top_checker.sv ====
// Purpose: Port assertions for the power-mode sequencer
// Assumes: One hclk domain, hresetn async active low
// Notes:   Bound to pms_top from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module pms_top_checker #(
    parameter int NBLK = 4,
    parameter int NRAM = 16
) (
    input wire logic            hclk,
    input wire logic            hresetn,
    input wire logic            enable_pin,
    input wire logic            gpio_detect,
    input wire logic            reset_req,
    input wire logic [NBLK-1:0] blk_active,
    input wire logic [NBLK-1:0] blk_idle,
    input wire logic            regulator_en,
    input wire logic            core_power_en,
    input wire logic            sys_reset_n,
    input wire logic            cpu_run,
    input wire logic            task_abort,
    input wire logic            res_reg_req,
    input wire logic            res_clk_req,
    input wire logic            base_res_en,
    input wire logic [NRAM-1:0] ram_power_on,
    input wire logic [NRAM-1:0] ram_retain
);
    // ======================================================================
    // Mode assertions
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_pin_low_off: assert property (!enable_pin |=> !regulator_en && !core_power_en)
        else $error("powered while disabled");
    a_pin_overrides: assert property (!enable_pin |=> !sys_reset_n && !base_res_en)
        else $error("mode survived disable");
    a_no_cpu_off: assert property (!enable_pin |=> !cpu_run)
        else $error("cpu running while disabled");
    a_enable_por: assert property (enable_pin && !regulator_en |=> !sys_reset_n [*8])
        else $error("no reset on enable");
    a_abort_halts: assert property (task_abort |-> !cpu_run)
        else $error("cpu runs in abort");
    a_detect_wake: assert property (task_abort && !core_power_en && enable_pin && gpio_detect
        |=> !sys_reset_n && !task_abort)
        else $error("no wake on detect");
    a_entry_wake: assert property (task_abort && core_power_en && enable_pin && reset_req
        |=> !sys_reset_n && !task_abort)
        else $error("no wake in entry");
    a_base_held: assert property (base_res_en && $past(base_res_en)
        |-> res_reg_req && res_clk_req)
        else $error("base resources dropped");
    a_idle_track: assert property (cpu_run && $past(cpu_run)
        |-> blk_idle == ~$past(blk_active))
        else $error("idle wrong");
    a_steer_track: assert property (cpu_run && $past(cpu_run) && !base_res_en
        && !$past(base_res_en) && !$past(base_res_en, 2)
        |-> res_reg_req == (|$past(blk_active)))
        else $error("steering wrong");
    a_ram_retain: assert property (task_abort && !core_power_en |-> ram_power_on == ram_retain)
        else $error("off ram power wrong");
endmodule // pms_top_checker
`default_nettype wire

// ==== testbench.sv ====
// Purpose: Self-checking bench for the power-mode sequencer
// Assumes: Zero-wait AHB-Lite slave, shortened reset counts
// Notes:   Read data is taken at the edge that ends the data phase
`timescale 1ns/1ps
`default_nettype none
`include "pms_consts.svh"
module testbench;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [3:0]  blk_active, blk_idle;
    logic [15:0] ram_power_on, ram_retain;
    logic        enable_pin, gpio_detect, reset_req, debug_start, debug_active;
    logic        regulator_en, core_power_en, sys_reset_n, cpu_run, task_abort;
    logic        res_reg_req, res_clk_req, base_res_en;
    wire logic   hready = hreadyout;
    int          err_count, compares;
    logic [31:0] r;

    // Short counts keep the run brief
    pms_top #(.POR_CYCLES(20), .WAKE_CYCLES(10)) i_dut (.*);
    pms_host_model i_host (.*);

    initial hclk = 1'b0;
    always #4 hclk = ~hclk;

    // ======================================================================
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {20'h0, a};
        hwrite <= w;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 100);
        r = hrdata;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(r, exp);
    endtask

    // Bounded wait for the system reset to lift
    task automatic wait_on;
        int n;
        n = 0;
        while (sys_reset_n !== 1'b1 && n < 200) begin
            @(posedge hclk);
            n++;
        end
        #1 check(sys_reset_n, 1'b1);
    endtask

    // ======================================================================
    // Scenarios
    task automatic s_power_on;
        rd_chk(`PMS_ADDR_STATUS, 32'h604);
        rd_chk(`PMS_ADDR_RAM_POWER, 32'h0000ffff);
        rd_chk(`PMS_ADDR_WAKE_CAUSE, 32'h8);
        check({hresp, hready}, 2'b01);
        bus(1'b1, 12'h010, 32'hffffffff);
        rd_chk(12'h010, 32'h0);
    endtask

    task automatic s_latency;
        blk_active <= 4'b0101;
        repeat (2) @(posedge hclk);
        #1 check({blk_idle, res_reg_req, res_clk_req}, 6'b1010_11);
        blk_active <= 4'b0000;
        repeat (2) @(posedge hclk);
        #1 check({blk_idle, res_reg_req, res_clk_req}, 6'b1111_00);
        bus(1'b1, `PMS_ADDR_TASKS, 32'h2);
        #1 check(base_res_en, 1'b1);
        rd_chk(`PMS_ADDR_STATUS, 32'h704);
        check(res_reg_req, 1'b1);
        bus(1'b1, `PMS_ADDR_TASKS, 32'h4);
        repeat (2) @(posedge hclk);
        #1 check({base_res_en, res_reg_req}, 2'b00);
        rd_chk(`PMS_ADDR_STATUS, 32'h604);
        bus(1'b1, `PMS_ADDR_RAM_POWER, 32'h00030005);
        #1 check({ram_retain, ram_power_on}, 32'h00030005);
    endtask

    task automatic s_off_wake;
        for (int k = 0; k < 3; k++) begin
            blk_active <= 4'b0000; // DMA and modem quiet first
            bus(1'b1, `PMS_ADDR_TASKS, 32'h1);
            #1 check({task_abort, cpu_run}, 2'b10);
            repeat (15) @(posedge hclk);
            #1 check(core_power_en, 1'b1);
            @(posedge hclk);
            #1 check(core_power_en, 1'b0);
            check(ram_power_on, 16'h0003);
            i_host.pulse(k);
            #1 check(sys_reset_n, 1'b0);
            wait_on;
            rd_chk(`PMS_ADDR_RAM_POWER, 32'h00030005);
            bus(1'b0, `PMS_ADDR_WAKE_CAUSE, 32'h0);
            check(r[k], 1'b1);
            bus(1'b1, `PMS_ADDR_WAKE_CAUSE, 32'hf);
        end
        rd_chk(`PMS_ADDR_WAKE_CAUSE, 32'h0);
    endtask

    task automatic s_entry_wake;
        bus(1'b1, `PMS_ADDR_TASKS, 32'h1);
        repeat (3) @(posedge hclk);
        i_host.pulse(1);
        #1 check({sys_reset_n, task_abort}, 2'b00);
        wait_on;
    endtask

    task automatic s_emulated;
        i_host.set_debug(1'b1);
        bus(1'b1, `PMS_ADDR_TASKS, 32'h1);
        #1 check({cpu_run, base_res_en, task_abort}, 3'b110);
        bus(1'b0, `PMS_ADDR_STATUS, 32'h0);
        check(r[6:0], 7'h20);
        repeat (4) @(posedge hclk); // software spins here
        #1 check(cpu_run, 1'b1);
        i_host.pulse(2);
        #1 check(sys_reset_n, 1'b0);
        i_host.set_debug(1'b0);
        wait_on;
    endtask

    task automatic s_disable;
        bus(1'b1, `PMS_ADDR_TASKS, 32'h2);
        i_host.set_enable(1'b0);
        @(posedge hclk);
        #1 check({regulator_en, core_power_en}, 2'b00);
        check({sys_reset_n, base_res_en, ram_power_on}, 18'h0);
        bus(1'b1, `PMS_ADDR_TASKS, 32'h2);
        bus(1'b0, `PMS_ADDR_STATUS, 32'h0);
        check({r[9:0], cpu_run}, 11'b0000000001_0);
        i_host.set_enable(1'b1);
        @(posedge hclk);
        #1 check({regulator_en, sys_reset_n}, 2'b10);
        bus(1'b0, `PMS_ADDR_STATUS, 32'h0);
        check(r[6:0], 7'h02);
        wait_on;
        rd_chk(`PMS_ADDR_STATUS, 32'h604);
        rd_chk(`PMS_ADDR_WAKE_CAUSE, 32'h8);
        rd_chk(`PMS_ADDR_RAM_POWER, 32'h0000ffff);
    endtask

    // ======================================================================
    // Run control
    task automatic report_and_stop;
        $display("errors %0d, compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        hresetn    = 1'b0;
        hsel       = 1'b0;
        haddr      = 32'h0;
        htrans     = 2'b00;
        hwrite     = 1'b0;
        hsize      = 3'b010;
        hwdata     = 32'h0;
        blk_active = 4'b0000;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        wait_on;
        s_power_on();
        s_latency();
        s_off_wake();
        s_entry_wake();
        s_emulated();
        s_disable();
        report_and_stop();
    end

    // Whole run needs a few hundred cycles
    initial begin
        #200000;
        err_count++;
        report_and_stop();
    end
endmodule // testbench

bind pms_top pms_top_checker #(.NBLK(NBLK), .NRAM(NRAM)) i_chk (.*);
`default_nettype wire
